// ==== dv/tb_top.sv ====
// Self-checking bench for txwm_csr with a link partner model.
// Assumes the design answers each bus request with waitrequest low.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import txwm_pkg::*;
;
	localparam logic [23:0] A_WM = TXWM_SPACE_BASE;
	localparam logic [23:0] A_BC = TXWM_SPACE_BASE + 24'h4;
	logic           clk, rstn, sv, drain, fc, send_allow, tx_fc_active;
	logic [1:0]     sp, avs_response, rsp;
	logic [5:0]     free;
	logic [31:0]    rd, seed, avs_readdata;
	logic           avs_waitrequest;
	txwm_avm_req_t  avs_req;
	txwm_marks_t    mk, marks_out;
	int             fail_count, n_checks;
	wire txwm_send_req_t send_req = '{sv, txwm_prio_t'(sp), free};
	txwm_csr #(.UNI_CLK(1'h1), .REORDER(1'h1), .TX_SIZE(11'h010),
		.RX_SIZE(8'h08)) txwm_csr_i (.clk, .rstn, .avs_req, .avs_readdata,
		.avs_waitrequest, .avs_response, .send_req, .send_allow,
		.tx_fc_active, .marks_out);
	txwm_partner txwm_partner_i (.clk, .rstn, .sent(send_allow), .drain,
		.free_space(free));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// Traffic is halted with each request, since marks must not move under it.
	// The wait is open ended; only the watchdog ends a stalled answer.
	task automatic bus(input logic [23:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		avs_req <= '{a, !w, w, 4'hf, d};
		sv <= 1'b0;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		rsp = avs_response;
		avs_req <= '{a, 1'b0, 1'b0, 4'hf, d};
	endtask
	task automatic rdchk(input string n, input logic [23:0] a,
		input logic [31:0] e, input logic [1:0] er);
		bus(a, 1'b0, 32'h0);
		chk(n, e, rd);
		chk("response", 32'(er), 32'(rsp));
	endtask
	// Offers one packet and predicts the gate from the bench's own marks.
	task automatic gate(input logic v, input logic [1:0] p);
		logic e;
		logic [5:0] m;
		@(posedge clk);
		sv <= v;
		sp <= p;
		drain <= seed[5];
		@(posedge clk);
		m = (p == 2'h0) ? mk.wm0 : (p == 2'h1) ? mk.wm1 : mk.wm2;
		e = v && (!fc || free >= m);
		#1;
		chk("send_allow", 32'(e), 32'(send_allow));
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		complete_run;
	end
	initial begin
		seed = 32'h6200;
		{fail_count, n_checks} = '0;
		{sv, sp, drain, avs_req} = '0;
		fc = 1'b1;
		mk = '{6'h01, 6'h02, 6'h03};
		rstn = 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		rdchk("marks", A_WM, 32'h00010203, 2'h0);
		rdchk("bufctl", A_BC, 32'h70100008, 2'h0);
		$display("test reset done");
		bus(A_WM, 1'b1, 32'hffc1c2c3);
		rdchk("marks", A_WM, 32'h00010203, 2'h0);
		bus(A_BC, 1'b1, 32'hffffffff);
		rdchk("bufctl", A_BC, 32'h50108008, 2'h0);
		chk("tx_fc_active", 32'h0, 32'(tx_fc_active));
		fc = 1'b0;
		repeat (8) begin
			seed = lfsr(seed);
			gate(seed[0], seed[2:1]);
		end
		bus(A_BC, 1'b1, 32'h0);
		fc = 1'b1;
		rdchk("bufctl", A_BC, 32'h70100008, 2'h0);
		$display("test force done");
		rdchk("hole", A_BC + 24'h4, 32'h0, 2'h3);
		bus(TXWM_SPACE_BASE - 24'h4, 1'b1, 32'hffffffff);
		rdchk("marks", A_WM, 32'h00010203, 2'h0);
		$display("test decode done");
		repeat (12) begin
			seed = lfsr(seed);
			mk.wm2 = 6'h01 + 6'(seed[3:0]);
			mk.wm1 = mk.wm2 + 6'h01 + 6'(seed[7:4]);
			mk.wm0 = mk.wm1 + 6'h01 + 6'(seed[11:8]);
			bus(A_WM, 1'b1, {10'h0, mk.wm2, 2'h0, mk.wm1, 2'h0, mk.wm0});
			#1 chk("marks_out", 32'(mk), 32'(marks_out));
			repeat (16) begin
				seed = lfsr(seed);
				gate(seed[0] | seed[9], seed[2:1]);
			end
		end
		$display("test gate done");
		complete_run;
	end
endmodule // tb_top
`default_nettype wire

// ==== dv/txwm_csr_props.sv ====
// Checker for the watermark and buffer control registers.
// Sees only the ports of txwm_csr; the bind follows the module.
`timescale 1ns/1ps
`default_nettype none
module txwm_csr_props
	import txwm_pkg::*;
(
	input wire logic           clk,
	input wire logic           rstn,
	input wire txwm_avm_req_t  avs_req,
	input wire logic [31:0]    avs_readdata,
	input wire logic           avs_waitrequest,
	input wire logic [1:0]     avs_response,
	input wire txwm_send_req_t send_req,
	input wire logic           send_allow,
	input wire logic           tx_fc_active,
	input wire txwm_marks_t    marks_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// A live request, and the cycle in which the slave answers it.
	wire logic rw  = avs_req.read | avs_req.write;
	wire logic ans = rw & !avs_waitrequest;
	wire logic hwm = avs_req.address == TXWM_SPACE_BASE;
	wire logic hbc = avs_req.address == TXWM_SPACE_BASE + 24'h4;
	// Gate inputs and the space tests that the send gate must apply.
	wire logic       gte = send_req.valid & tx_fc_active;
	wire logic [5:0] fs  = send_req.free_space;
	wire logic       ok2 = fs >= marks_out.wm2;
	wire logic       ok1 = fs >= marks_out.wm1;
	wire logic       ok0 = fs >= marks_out.wm0;
	sequence s_start; $rose(rw); endsequence
	sequence s_answer; avs_waitrequest ##1 !avs_waitrequest; endsequence
	a_answer_lat: assert property (s_start |=> s_answer)
		else $error("bus answer late or early");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_decode_err: assert property (ans && !(hwm || hbc) |->
		avs_response == 2'h3 && avs_readdata == TXWM_UNMAPPED)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (ans && (hwm || hbc) |-> !avs_response)
		else $error("mapped access refused");
	a_marks_read: assert property (ans && avs_req.read && hwm |->
		avs_readdata == {10'h0, marks_out.wm2, 2'h0, marks_out.wm1,
		2'h0, marks_out.wm0}) else $error("watermark readback wrong");
	a_fc_bit: assert property (ans && avs_req.read && hbc |->
		avs_readdata[29] == tx_fc_active && !avs_readdata[27])
		else $error("flow control bit wrong");
	a_gate_prio2: assert property (gte && send_req.prio[1] |=>
		send_allow == $past(ok2)) else $error("priority 2 gate wrong");
	a_gate_prio1: assert property (gte && send_req.prio == TXWM_PRIO1 |=>
		send_allow == $past(ok1)) else $error("priority 1 gate wrong");
	a_gate_prio0: assert property (gte && send_req.prio == TXWM_PRIO0 |=>
		send_allow == $past(ok0)) else $error("priority 0 gate wrong");
	a_rx_fc_pass: assert property (!tx_fc_active |=>
		send_allow == $past(send_req.valid)) else $error("ungated send wrong");
endmodule // txwm_csr_props
bind txwm_csr txwm_csr_props txwm_csr_props_i (.clk, .rstn, .avs_req,
	.avs_readdata, .avs_waitrequest, .avs_response, .send_req,
	.send_allow, .tx_fc_active, .marks_out);
`default_nettype wire

// ==== dv/txwm_partner.sv ====
// Link partner model: free space of its receive buffer.
// Assumes one slot is used per allowed packet and freed per drain pulse.
`timescale 1ns/1ps
`default_nettype none
module txwm_partner #(
	parameter logic [5:0] DEPTH = 6'h20 // Slots in the partner buffer.
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       sent,
	input  wire logic       drain,
	output var  logic [5:0] free_space
);
	// A slow partner is modelled by the bench holding drain low.
	always_ff @(posedge clk) begin
		if (!rstn)
			free_space <= DEPTH;
		else
			free_space <= free_space - 6'(sent && free_space != 6'h0)
				+ 6'(drain && free_space < DEPTH);
	end
endmodule // txwm_partner
`default_nettype wire

// ==== hdl/txwm_csr.sv ====
// Transmit flow watermark and buffer control registers with send gate.
// Assumes one clock, an Avalon-MM master and synchronous inputs.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module txwm_csr
	import txwm_pkg::*;
#(
	parameter logic        RX_ONLY   = 1'h0,            // Receiver-only build.
	parameter logic        UNI_CLK   = 1'h0,            // Single clock build.
	parameter logic        REORDER   = 1'h0,            // Reordering allowed.
	parameter logic [10:0] TX_SIZE   = TXWM_TXSIZE_DEF, // Transmit depth.
	parameter logic [7:0]  RX_SIZE   = TXWM_RXSIZE_DEF  // Receive depth.
)
(
	input  wire logic           clk,             // System clock.
	input  wire logic           rstn,            // Synchronous reset, low.
	input  wire txwm_avm_req_t  avs_req,         // Avalon-MM request.
	output var  logic [31:0]    avs_readdata,    // Read data.
	output var  logic           avs_waitrequest, // Stall until answered.
	output var  logic [1:0]     avs_response,    // 00 okay, 11 decode error.
	input  wire txwm_send_req_t send_req,        // Packet offered to send.
	output var  logic           send_allow,      // Packet may go now.
	output var  logic           tx_fc_active,    // Transmitter flow control.
	output var  txwm_marks_t    marks_out        // Watermarks to the buffer.
);

	// Whole state of the register block in one struct.
	typedef struct packed {
		txwm_bus_st_t bus;     // Bus handshake state.
		txwm_marks_t  marks;   // Stored watermarks.
		logic         force_rx;// Force receiver flow control.
		logic         tx_fc;   // Transmitter flow control in effect.
		logic [31:0]  rdata;   // Read data held for the master.
		logic         wait_n;  // Inverted waitrequest.
		logic [1:0]   resp;    // Response code.
	} txwm_st_t;

	txwm_st_t    st;        // Registered state.
	txwm_st_t    next_st;   // Next state.
	txwm_marks_t mrg_marks; // Watermarks after a write merge.
	logic        mrg_force; // Force bit after a write merge.
	logic        gate_allow;// Allowance from the gate.

	// True when the address hits the block at the given offset.
	function automatic logic hit(logic [23:0] a, logic [7:0] ofs);
		hit = (a == (TXWM_SPACE_BASE | 24'(ofs)));
	endfunction

	// Read image of the watermark register; reserved bits read zero.
	function automatic logic [31:0] wm_image(txwm_marks_t m);
		logic [31:0] v;
		v = '0;
		v[TXWM_WM2_LSB +: TXWM_WM_W] = m.wm2;
		v[TXWM_WM1_LSB +: TXWM_WM_W] = m.wm1;
		v[TXWM_WM0_LSB +: TXWM_WM_W] = m.wm0;
		return v;
	endfunction

	// Read image of the buffer control register.
	function automatic logic [31:0] bc_image(logic fc, logic frc);
		logic [31:0] v;
		v = '0;
		v[TXWM_RXONLY_BIT] = RX_ONLY;
		v[TXWM_UNICLK_BIT] = UNI_CLK;
		v[TXWM_TXFC_BIT]   = fc;
		v[TXWM_REORD_BIT]  = REORDER;
		v[TXWM_TXSIZE_LSB +: TXWM_TXSIZE_W] = TX_SIZE;
		v[TXWM_FORCE_BIT]  = frc;
		v[TXWM_RXSIZE_LSB +: TXWM_RXSIZE_W] = RX_SIZE;
		return v;
	endfunction

	// Byte-lane merge of write data into the writable fields.
	txwm_fields u_fields (
		.wdata     (avs_req.writedata),
		.be        (avs_req.byteenable),
		.old_marks (st.marks),
		.old_force (st.force_rx),
		.new_marks (mrg_marks),
		.new_force (mrg_force)
	);

	// Per-priority send gate.
	txwm_gate u_gate (
		.clk   (clk),
		.rstn  (rstn),
		.req   (send_req),
		.marks (st.marks),
		.tx_fc (st.tx_fc),
		.allow (gate_allow)
	);

	// Bus slave: every request is answered two edges after it is seen.
	// The answer waits a cycle so read data and waitrequest stay
	// registered, which trades one cycle of latency for clean timing.
	always_comb begin
		next_st = st;
		case (st.bus)
			TXWM_IDLE: begin
				next_st.wait_n = 1'b0;
				if (avs_req.read || avs_req.write) begin
					next_st.bus = TXWM_ANSWER;
				end
			end
			TXWM_ANSWER: begin
				// Decode, apply the write and load the read image.
				next_st.wait_n = 1'b1;
				next_st.bus    = TXWM_DONE;
				next_st.resp   = 2'h0;
				next_st.rdata  = TXWM_UNMAPPED;
				if (hit(avs_req.address, TXWM_OFS_WMARK)) begin
					if (avs_req.write) begin
						next_st.marks = mrg_marks;
					end else begin
						next_st.rdata = wm_image(st.marks);
					end
				end else if (hit(avs_req.address, TXWM_OFS_BUFCTL)) begin
					if (avs_req.write && !RX_ONLY) begin
						next_st.force_rx = mrg_force;
					end else if (avs_req.read) begin
						next_st.rdata = bc_image(st.tx_fc, st.force_rx);
					end
					// A receiver-only build drops the write entirely.
				end else begin
					// Unmapped addresses complete with a decode error.
					next_st.resp = 2'h3;
				end
			end
			TXWM_DONE: begin
				// Master samples the answer here and drops its request.
				next_st.wait_n = 1'b0;
				next_st.bus    = TXWM_IDLE;
			end
			default: begin
				next_st.bus    = TXWM_IDLE;
				next_st.wait_n = 1'b0;
			end
		endcase
		// Flow control mode follows the build and the force bit.
		next_st.tx_fc = !RX_ONLY && !next_st.force_rx;
	end

	// Register the whole state; reset loads the safe watermarks.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st.bus      <= TXWM_IDLE;
			st.marks    <= '{wm2: TXWM_WM2_RST, wm1: TXWM_WM1_RST,
			                 wm0: TXWM_WM0_RST};
			st.force_rx <= TXWM_FORCE_RST;
			st.tx_fc    <= 1'b0;
			st.rdata    <= '0;
			st.wait_n   <= 1'b0;
			st.resp     <= 2'h0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs come straight from flip-flops.
	assign avs_readdata    = st.rdata;
	assign avs_waitrequest = !st.wait_n;
	assign avs_response    = st.resp;
	assign send_allow      = gate_allow;
	assign tx_fc_active    = st.tx_fc;
	assign marks_out       = st.marks;

endmodule // txwm_csr
`default_nettype wire

// ==== hdl/txwm_fields.sv ====
// Write merge for the writable fields of both registers.
// Pure combinational helper; byte enables come from the bus master.
`timescale 1ns/1ps
`default_nettype none
module txwm_fields
	import txwm_pkg::*;
(
	input  wire logic [31:0] wdata,     // Write data.
	input  wire logic [3:0]  be,        // Byte enables.
	input  wire txwm_marks_t old_marks, // Present watermarks.
	input  wire logic        old_force, // Present force bit.
	output var  txwm_marks_t new_marks, // Merged watermarks.
	output var  logic        new_force  // Merged force bit.
);

	// Only the watermark bits and the force bit are stored; reserved bits are dropped.
	always_comb begin
		new_marks = old_marks;
		new_force = old_force;
		if (be[2]) begin
			new_marks.wm2 = wdata[TXWM_WM2_LSB +: TXWM_WM_W];
		end
		if (be[1]) begin
			new_marks.wm1 = wdata[TXWM_WM1_LSB +: TXWM_WM_W];
			new_force     = wdata[TXWM_FORCE_BIT];
		end
		if (be[0]) begin
			new_marks.wm0 = wdata[TXWM_WM0_LSB +: TXWM_WM_W];
		end
	end

endmodule // txwm_fields
`default_nettype wire

// ==== hdl/txwm_gate.sv ====
// Priority send gate: compares partner free space with watermarks.
// Assumes the request fields are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module txwm_gate
	import txwm_pkg::*;
(
	input  wire logic           clk,      // System clock.
	input  wire logic           rstn,     // Synchronous reset, low.
	input  wire txwm_send_req_t req,      // Offered packet.
	input  wire txwm_marks_t    marks,    // Current watermarks.
	input  wire logic           tx_fc,    // Transmitter flow control on.
	output var  logic           allow     // Registered send allowance.
);

	// Threshold chosen for the offered priority.
	function automatic logic [5:0] pick_mark(txwm_prio_t p, txwm_marks_t m);
		case (p)
			TXWM_PRIO0: pick_mark = m.wm0;
			TXWM_PRIO1: pick_mark = m.wm1;
			TXWM_PRIO2: pick_mark = m.wm2;
			default:    pick_mark = m.wm2; // Highest class, lowest mark.
		endcase
	endfunction

	// State held by this module.
	typedef struct packed {
		logic allow;
	} txwm_gate_st_t;

	txwm_gate_st_t st;       // Registered state.
	txwm_gate_st_t next_st;  // Next state.

	// Under receiver flow control the partner retries, so no gating.
	always_comb begin
		next_st = st;
		if (!req.valid) begin
			next_st.allow = 1'b0;
		end else if (tx_fc) begin
			next_st.allow = (req.free_space >= pick_mark(req.prio, marks));
		end else begin
			next_st.allow = 1'b1;
		end
	end

	// Register the allowance.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign allow = st.allow;

endmodule // txwm_gate
`default_nettype wire

// ==== hdl/txwm_pkg.sv ====
// Package for the transmit flow watermark and buffer control registers.
// Assumes a single 10 MHz clock domain and an Avalon-MM register bus.
package txwm_pkg;

	// Byte offset of the register block in implementation space.
	localparam logic [23:0] TXWM_SPACE_BASE   = 24'h010000;
	// Byte offsets of the two registers within the block.
	localparam logic [7:0]  TXWM_OFS_WMARK    = 8'h00;
	localparam logic [7:0]  TXWM_OFS_BUFCTL   = 8'h04;
	// Bus address width in bits; the block decodes all of them.
	localparam int          TXWM_ADDR_W       = 24;

	// Watermark field positions.
	localparam int          TXWM_WM2_LSB      = 16;
	localparam int          TXWM_WM1_LSB      = 8;
	localparam int          TXWM_WM0_LSB      = 0;
	localparam int          TXWM_WM_W         = 6;

	// Buffer control field positions.
	localparam int          TXWM_RXONLY_BIT   = 31;
	localparam int          TXWM_UNICLK_BIT   = 30;
	localparam int          TXWM_TXFC_BIT     = 29;
	localparam int          TXWM_REORD_BIT    = 28;
	localparam int          TXWM_TXSIZE_LSB   = 16;
	localparam int          TXWM_TXSIZE_W     = 11;
	localparam int          TXWM_FORCE_BIT    = 15;
	localparam int          TXWM_RXSIZE_LSB   = 0;
	localparam int          TXWM_RXSIZE_W     = 8;

	// Default watermarks: the conservative safe choice.
	localparam logic [5:0]  TXWM_WM0_RST      = 6'h03;
	localparam logic [5:0]  TXWM_WM1_RST      = 6'h02;
	localparam logic [5:0]  TXWM_WM2_RST      = 6'h01;
	// Reset value of the force bit, and default build options.
	localparam logic        TXWM_FORCE_RST    = 1'h0;
	localparam logic [10:0] TXWM_TXSIZE_DEF   = 11'h020;
	localparam logic [7:0]  TXWM_RXSIZE_DEF   = 8'h20;
	// Value returned on unmapped reads.
	localparam logic [31:0] TXWM_UNMAPPED     = 32'h00000000;

	// Packet priorities that may be offered for sending.
	typedef enum logic [1:0] {
		TXWM_PRIO0,
		TXWM_PRIO1,
		TXWM_PRIO2,
		TXWM_PRIO3
	} txwm_prio_t;

	// The three watermarks as one carrier.
	typedef struct packed {
		logic [5:0] wm2;
		logic [5:0] wm1;
		logic [5:0] wm0;
	} txwm_marks_t;

	// Avalon-MM request from the master.
	typedef struct packed {
		logic [23:0] address;
		logic        read;
		logic        write;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} txwm_avm_req_t;

	// Request to send one packet, and the partner's free space.
	typedef struct packed {
		logic       valid;
		txwm_prio_t prio;
		logic [5:0] free_space;
	} txwm_send_req_t;

	// Bus states of the register slave.
	typedef enum logic [1:0] {
		TXWM_IDLE,
		TXWM_ANSWER,
		TXWM_DONE
	} txwm_bus_st_t;

endpackage : txwm_pkg
